// ---- reply_regs.sv ----
/*
  Descriptor reply pointer and total, byte read port fed through a
  small FIFO, and the first DMA channel's buffer control bits.
  Assumes a synchronous CPU register strobe interface on CLOCK, and that
  the endpoint buffer, reply engine and DMA engine sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "reply_regs_defs.svh"
module reply_regs #(
  parameter int                     FIFO_WIDTH = 8,
  parameter int                     FIFO_DEPTH = `FIFO_DEPTH,
  parameter logic [`LEN_WIDTH-1:0]  MAX_PACKET = `MAX_PACKET_DEFAULT
) (
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  // CPU register port
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [7:0]            REG_WDATA,
  output logic [7:0]                 REG_RDATA,
  // Reply engine
  input  wire logic                  REPLY_ACTIVE,
  input  wire logic                  IN_DONE,
  input  wire logic [`LEN_WIDTH-1:0] IN_BYTES_SENT,
  output logic [`PTR_WIDTH-1:0]      REPLY_START_POINTER,
  output logic [`LEN_WIDTH-1:0]      REPLY_BYTE_TOTAL,
  // Endpoint buffer read stream
  input  wire logic                  CPU_READ_ATTACH,
  input  wire logic [11:0]           READABLE_BYTE_COUNT,
  input  wire logic                  BUF_VALID,
  output logic                       BUF_READY,
  input  wire logic [7:0]            BUF_DATA,
  output logic                       READABLE_COUNT_VALID,
  // First DMA channel
  input  wire logic                  DMA_START,
  input  wire logic                  DMA_FINISH,
  input  wire logic                  DMA_BUF_EMPTY,
  input  wire logic                  DMA_EP_IS_IN,
  input  wire logic [`LEN_WIDTH-1:0] DMA_BUF_REMAIN,
  output logic                       BUFFER_ACTIVE,
  output logic                       SHORT_PACKET_ENABLE_SET
);
  reply_regs_pkg::chan_state_type state;
  reply_regs_pkg::chan_state_type next_state;
  logic [`PTR_WIDTH-1:0] reply_start_pointer;
  logic [`LEN_WIDTH-1:0] reply_byte_total;
  logic                  auto_short_packet_arm;
  logic                  fifo_valid;
  logic [7:0]            fifo_data;
  logic                  port_read;
  logic                  wr_ptr_high;
  logic                  wr_ptr_low;
  logic                  wr_len_high;
  logic                  wr_len_low;
  logic                  wr_ctrl;
  logic                  short_pulse;
  logic [7:0]            next_rdata;

  // Write strobes per register, reserved addresses decode to nothing
  assign wr_ptr_high = REG_WR && (REG_ADDR == `ADDR_PTR_HIGH);
  assign wr_ptr_low  = REG_WR && (REG_ADDR == `ADDR_PTR_LOW);
  assign wr_len_high = REG_WR && (REG_ADDR == `ADDR_LEN_HIGH);
  assign wr_len_low  = REG_WR && (REG_ADDR == `ADDR_LEN_LOW);
  assign wr_ctrl     = REG_WR && (REG_ADDR == `ADDR_DMA_CTRL);
  // A port read pops one byte only when the buffer is attached
  assign port_read   = REG_RD && (REG_ADDR == `ADDR_BYTE_PORT)
                       && CPU_READ_ATTACH;

  // Reply start pointer: CPU writes, advance on each finished IN while REPLY_ACTIVE
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      reply_start_pointer <= `PTR_RESET;
    end else if (REPLY_ACTIVE && IN_DONE) begin
      // Hardware update wins over a simultaneous CPU write
      reply_start_pointer <= reply_start_pointer
        + `PTR_WIDTH'(IN_BYTES_SENT);
    end else if (wr_ptr_high) begin
      // Whole range accepted, no clamp to endpoint areas
      reply_start_pointer[`PTR_WIDTH-1:8] <=
        REG_WDATA[`PTR_HIGH_BITS-1:0];
    end else if (wr_ptr_low) begin
      reply_start_pointer[7:0] <= REG_WDATA;
    end
  end

  // Reply byte total: CPU writes, reduce on each finished IN while REPLY_ACTIVE
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      reply_byte_total <= `LEN_RESET;
    end else if (REPLY_ACTIVE && IN_DONE) begin
      reply_byte_total <= (IN_BYTES_SENT > reply_byte_total) ? '0
        : reply_byte_total - IN_BYTES_SENT;
    end else if (wr_len_high) begin
      reply_byte_total[`LEN_WIDTH-1:8] <=
        REG_WDATA[`LEN_HIGH_BITS-1:0];
    end else if (wr_len_low) begin
      reply_byte_total[7:0] <= REG_WDATA;
    end
  end

  assign REPLY_START_POINTER = reply_start_pointer;
  assign REPLY_BYTE_TOTAL    = reply_byte_total;

  // Prefetch buffer between endpoint store and the byte port
  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (BUF_VALID && CPU_READ_ATTACH),
    .in_ready  (BUF_READY),
    .in_data   (BUF_DATA),
    .out_valid (fifo_valid),
    .out_ready (port_read),
    .out_data  (fifo_data)
  );

  // Count valid only while attached for reading
  assign READABLE_COUNT_VALID = CPU_READ_ATTACH;

  // Automatic short packet arm, CPU writable
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      auto_short_packet_arm <= 1'b0;
    end else if (wr_ctrl) begin
      auto_short_packet_arm <= REG_WDATA[`CTRL_ARM_BIT];
    end
  end

  // Channel activity sequence
  always_comb begin
    next_state = state;
    case (state)
      reply_regs_pkg::CHAN_IDLE: begin
        if (DMA_START) begin
          next_state = reply_regs_pkg::CHAN_RUN;
        end
      end
      reply_regs_pkg::CHAN_RUN: begin
        if (DMA_FINISH) begin
          next_state = DMA_BUF_EMPTY ? reply_regs_pkg::CHAN_IDLE
                                     : reply_regs_pkg::CHAN_DRAIN;
        end
      end
      reply_regs_pkg::CHAN_DRAIN: begin
        if (DMA_START) begin
          next_state = reply_regs_pkg::CHAN_RUN;
        end else if (DMA_BUF_EMPTY) begin
          next_state = reply_regs_pkg::CHAN_IDLE;
        end
      end
      default: begin
        next_state = reply_regs_pkg::CHAN_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= reply_regs_pkg::CHAN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Active while running or draining
  assign BUFFER_ACTIVE = (state != reply_regs_pkg::CHAN_IDLE);

  // Short packet enable request at channel end
  assign short_pulse = auto_short_packet_arm && DMA_EP_IS_IN
    && (state == reply_regs_pkg::CHAN_RUN) && DMA_FINISH
    && (DMA_BUF_REMAIN != '0)
    && (DMA_BUF_REMAIN < MAX_PACKET);

  // Registered one-cycle request
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SHORT_PACKET_ENABLE_SET <= 1'b0;
    end else begin
      SHORT_PACKET_ENABLE_SET <= short_pulse;
    end
  end

  // Read data mux, reserved bits and addresses give zero
  always_comb begin
    next_rdata = 8'h00;
    case (REG_ADDR)
      `ADDR_PTR_HIGH: begin
        next_rdata[`PTR_HIGH_BITS-1:0] =
          reply_start_pointer[`PTR_WIDTH-1:8];
      end
      `ADDR_PTR_LOW: begin
        next_rdata = reply_start_pointer[7:0];
      end
      `ADDR_LEN_HIGH: begin
        next_rdata[`LEN_HIGH_BITS-1:0] = reply_byte_total[`LEN_WIDTH-1:8];
      end
      `ADDR_LEN_LOW: begin
        next_rdata = reply_byte_total[7:0];
      end
      `ADDR_BYTE_PORT: begin
        next_rdata = (port_read && fifo_valid) ? fifo_data : 8'h00;
      end
      `ADDR_DMA_CTRL: begin
        next_rdata[`CTRL_ACTIVE_BIT] = BUFFER_ACTIVE;
        next_rdata[`CTRL_ARM_BIT]    = auto_short_packet_arm;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Registered read data, captured on a read strobe
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- reply_regs_defs.svh ----
/*
  Offsets, field positions, reset values and sizes of the descriptor
  reply and byte read register slice. Included by the reply_regs module.
*/
`ifndef REPLY_REGS_DEFS_SVH
`define REPLY_REGS_DEFS_SVH
`define ADDR_PTR_HIGH      8'h78
`define ADDR_PTR_LOW       8'h79
`define ADDR_LEN_HIGH      8'h7a
`define ADDR_LEN_LOW       8'h7b
`define ADDR_BYTE_PORT     8'h7c
`define ADDR_RSVD_FIRST    8'h7d
`define ADDR_RSVD_LAST     8'h7f
`define ADDR_DMA_CTRL      8'h80
`define PTR_WIDTH          12
`define LEN_WIDTH          10
`define PTR_HIGH_BITS      4
`define LEN_HIGH_BITS      2
`define PTR_RESET          12'h000
`define LEN_RESET          10'h000
`define BUF_LAST_ADDR      12'h9ff
`define CTRL_ACTIVE_BIT    7
`define CTRL_ARM_BIT       6
`define FIFO_DEPTH         16
`define MAX_PACKET_DEFAULT 10'h040
`endif

// ---- reply_regs_pkg.sv ----
/*
  Types shared by the register slice. No assumptions on surroundings.
*/
`default_nettype none
package reply_regs_pkg;
  typedef enum logic [1:0] {
    CHAN_IDLE,
    CHAN_RUN,
    CHAN_DRAIN
  } chan_state_type;
endpackage
`default_nettype wire

// ---- byte_fifo.sv ----
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- reply_regs_monitor.sv ----
/* Port assertions for the reply register slice.
   Bound to reply_regs; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module reply_regs_monitor #(parameter logic [9:0] MAX_PACKET = 10'h040) (
  // Clock, reset and register port
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Reply engine and stream
  input wire logic REPLY_ACTIVE,
  input wire logic IN_DONE,
  input wire logic [9:0] IN_BYTES_SENT,
  input wire logic [11:0] REPLY_START_POINTER,
  input wire logic [9:0] REPLY_BYTE_TOTAL,
  input wire logic CPU_READ_ATTACH,
  input wire logic READABLE_COUNT_VALID,
  // First DMA channel
  input wire logic DMA_START,
  input wire logic DMA_FINISH,
  input wire logic DMA_BUF_EMPTY,
  input wire logic DMA_EP_IS_IN,
  input wire logic [9:0] DMA_BUF_REMAIN,
  input wire logic BUFFER_ACTIVE,
  input wire logic SHORT_PACKET_ENABLE_SET
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Reply engine updates, CPU writes and reads, and the valid flag
  a_ptr_step: assert property (REPLY_ACTIVE && IN_DONE |=>
    REPLY_START_POINTER == 12'($past(REPLY_START_POINTER)
    + $past(IN_BYTES_SENT))) else $error("pointer step wrong");
  a_total_step: assert property (REPLY_ACTIVE && IN_DONE |=>
    REPLY_BYTE_TOTAL == ($past(REPLY_BYTE_TOTAL) > $past(IN_BYTES_SENT)
    ? $past(REPLY_BYTE_TOTAL) - $past(IN_BYTES_SENT) : 10'h000))
    else $error("total step wrong");
  a_low_write: assert property (REG_WR && REG_ADDR == 8'h79 &&
    !(REPLY_ACTIVE && IN_DONE) |=> REPLY_START_POINTER[7:0] ==
    $past(REG_WDATA)) else $error("pointer low write lost");
  a_ptr_high: assert property (REG_RD && REG_ADDR == 8'h78 |=>
    REG_RDATA == 8'($past(REPLY_START_POINTER) >> 8))
    else $error("pointer high read wrong");
  a_rsvd_zero: assert property (REG_RD &&
    REG_ADDR inside {[8'h7d:8'h7f]} |=> REG_RDATA == 8'h00)
    else $error("reserved read not zero");
  a_ctrl_read: assert property (REG_RD && REG_ADDR == 8'h80 |=>
    REG_RDATA[7] == $past(BUFFER_ACTIVE) && REG_RDATA[5:0] == 6'h00)
    else $error("control read wrong");
  a_valid_tie: assert property (
    READABLE_COUNT_VALID == CPU_READ_ATTACH) else $error("valid flag wrong");
  // Channel activity and short packet pulse
  a_active_set: assert property (DMA_START |=> BUFFER_ACTIVE)
    else $error("active not set");
  a_active_clear: assert property (DMA_FINISH &&
    DMA_BUF_EMPTY && !DMA_START |=> !BUFFER_ACTIVE)
    else $error("active not cleared");
  a_short_cause: assert property (SHORT_PACKET_ENABLE_SET |->
    $past(DMA_FINISH && DMA_EP_IS_IN && DMA_BUF_REMAIN != 10'h000
    && DMA_BUF_REMAIN < MAX_PACKET)) else $error("short pulse unprompted");
endmodule
bind reply_regs reply_regs_monitor #(.MAX_PACKET(MAX_PACKET))
  reply_regs_monitor_inst (.*);
`default_nettype wire

// ---- buf_source.sv ----
/* Endpoint buffer model feeding the byte stream in order.
   Assumes one clock; the bench loads its queue before reset ends. */
`timescale 1ns/1ps
`default_nettype none
module buf_source (
  // Clock and reset
  input  wire logic  CLOCK,
  input  wire logic  RST_N,
  // Pacing and attach
  input  wire logic  stall,
  input  wire logic  CPU_READ_ATTACH,
  // Stream
  input  wire logic  BUF_READY,
  output logic       BUF_VALID,
  output logic [7:0] BUF_DATA
);
  logic [7:0] q[$];
  logic       keep;
  // Offer still pending
  assign keep = BUF_VALID && !(BUF_READY && CPU_READ_ATTACH);
  // Hold each byte until taken, scramble data when idle
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BUF_VALID <= 1'b0;
      BUF_DATA <= 8'h00;
    end else begin
      if (BUF_VALID && !keep)
        void'(q.pop_front());
      if (q.size() > 0 && (keep || !stall)) begin
        BUF_VALID <= 1'b1;
        BUF_DATA <= q[0];
      end else begin
        BUF_VALID <= 1'b0;
        BUF_DATA <= ~BUF_DATA;
      end
    end
  end
endmodule
`default_nettype wire

// ---- reply_regs_tb.sv ----
/* Self-checking bench for the reply register slice.
   Assumes the slice, FIFO, monitor and buffer model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module reply_regs_tb;
  logic CLOCK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, stall = 0;
  logic REPLY_ACTIVE = 0, IN_DONE = 0, CPU_READ_ATTACH = 0, BUF_VALID;
  logic DMA_START = 0, DMA_FINISH = 0, DMA_BUF_EMPTY = 0, DMA_EP_IS_IN = 0;
  logic BUF_READY, READABLE_COUNT_VALID, BUFFER_ACTIVE;
  logic SHORT_PACKET_ENABLE_SET;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, BUF_DATA, rd_data;
  logic [9:0] IN_BYTES_SENT = 0, DMA_BUF_REMAIN = 0, REPLY_BYTE_TOTAL;
  logic [11:0] READABLE_BYTE_COUNT = 0, REPLY_START_POINTER;
  logic [9:0] rem_t[5] = '{10'h005, 10'h040, 10'h005, 10'h005, 10'h03f};
  logic [4:0] arm_t = 5'b11011, in_t = 5'b10111, sh_t = 5'b10001;
  logic [7:0] exp_q[$];
  int ptr, len, sent, pulses, err_count, check_count;
  integer seed = 64399;
  reply_regs reply_regs_inst (.*);
  buf_source buf_source_inst (.*);
  // Clock, random pacing and pulse count
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) stall <= 1'($random(seed));
  always @(posedge CLOCK) if (SHORT_PACKET_ENABLE_SET === 1'b1) pulses++;
  task automatic chk(string what, int exp, logic [11:0] got);
    check_count++;
    if (got !== 12'(exp)) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(negedge CLOCK);
    rd_data = REG_RDATA;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 20000);
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (20) begin
      sent = $random(seed);
      exp_q.push_back(8'(sent));
      buf_source_inst.q.push_back(8'(sent));
    end
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(8'h7a);
    chk("total reset", 0, rd_data);
    for (int i = 0; i < 4; i++) begin
      // Case 2 sits between the control area end and the command area
      ptr = (i == 2) ? 'h040 : (i == 1) ? 'h9ff : (i == 0) ? 0
          : $unsigned($random(seed)) % 'ha00;
      len = (i == 2) ? 'h150 : (i == 1) ? 'h3ff
          : $unsigned($random(seed)) % 'h400;
      wr(8'h78, 8'hf0 | 8'(ptr >> 8));
      wr(8'h79, 8'(ptr));
      wr(8'h7a, 8'hfc | 8'(len >> 8));
      wr(8'h7b, 8'(len));
      rd(8'h78);
      chk("ptr high", ptr >> 8, rd_data);
      rd(8'h79);
      chk("ptr low", ptr & 'hff, rd_data);
      rd(8'h7a);
      chk("total high", len >> 8, rd_data);
      rd(8'h7b);
      chk("total low", len & 'hff, rd_data);
      chk("ptr out", ptr, REPLY_START_POINTER);
      chk("total out", len, REPLY_BYTE_TOTAL);
    end
    for (int j = 0; j < 6; j++) begin
      sent = (j == 5) ? 'h3ff : $unsigned($random(seed)) % 64;
      @(posedge CLOCK);
      REPLY_ACTIVE <= (j != 2);
      IN_BYTES_SENT <= 10'(sent);
      IN_DONE <= 1'b1;
      // Case 3 also writes the pointer low byte; the update must win
      REG_ADDR <= 8'h79;
      REG_WDATA <= 8'h5a;
      REG_WR <= (j == 3);
      @(posedge CLOCK);
      IN_DONE <= 1'b0;
      REG_WR <= 1'b0;
      if (j != 2) begin
        ptr = (ptr + sent) % 4096;
        len = (len > sent) ? len - sent : 0;
      end
      @(negedge CLOCK);
      chk("ptr step", ptr, REPLY_START_POINTER);
      chk("total step", len, REPLY_BYTE_TOTAL);
    end
    for (int a = 'h7d; a < 'h80; a++) begin
      wr(8'(a), 8'hff);
      rd(8'(a));
      chk("reserved", 0, rd_data);
    end
    chk("ptr kept", ptr, REPLY_START_POINTER);
    rd(8'h7c);
    chk("detached", 0, rd_data);
    @(posedge CLOCK);
    CPU_READ_ATTACH <= 1'b1;
    READABLE_BYTE_COUNT <= 12'(exp_q.size());
    repeat (60) @(posedge CLOCK);
    @(negedge CLOCK);
    chk("full", 0, BUF_READY);
    chk("count valid", 1, READABLE_COUNT_VALID);
    // Take only as many bytes as the readable count allows
    repeat (READABLE_BYTE_COUNT) begin
      rd(8'h7c);
      chk("byte", exp_q.pop_front(), rd_data);
    end
    rd(8'h7c);
    chk("empty", 0, rd_data);
    for (int k = 0; k < 5; k++) begin
      wr(8'h80, arm_t[k] ? 8'hff : 8'h00);
      rd(8'h80);
      chk("arm", arm_t[k] ? 'h40 : 0, rd_data);
      @(posedge CLOCK);
      DMA_START <= 1'b1;
      DMA_EP_IS_IN <= in_t[k];
      DMA_BUF_REMAIN <= rem_t[k];
      @(posedge CLOCK);
      DMA_START <= 1'b0;
      rd(8'h80);
      chk("running", arm_t[k] ? 'hc0 : 'h80, rd_data);
      pulses = 0;
      @(posedge CLOCK);
      DMA_FINISH <= 1'b1;
      DMA_BUF_EMPTY <= (k == 4);
      @(posedge CLOCK);
      DMA_FINISH <= 1'b0;
      DMA_BUF_EMPTY <= 1'b0;
      repeat (2) @(negedge CLOCK);
      chk("short", sh_t[k], 12'(pulses));
      chk("held", k != 4, BUFFER_ACTIVE);
      // Case 0 restarts the channel while it drains; a start wins
      @(posedge CLOCK);
      DMA_START <= (k == 0);
      DMA_BUF_EMPTY <= 1'b1;
      @(posedge CLOCK);
      DMA_START <= 1'b0;
      DMA_BUF_EMPTY <= 1'b0;
      @(negedge CLOCK);
      chk("drain end", k == 0, BUFFER_ACTIVE);
      if (k == 0) begin
        @(posedge CLOCK);
        DMA_FINISH <= 1'b1;
        DMA_BUF_EMPTY <= 1'b1;
        @(posedge CLOCK);
        DMA_FINISH <= 1'b0;
        DMA_BUF_EMPTY <= 1'b0;
        @(negedge CLOCK);
        chk("restart end", 0, BUFFER_ACTIVE);
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
